// ==== design/flash_level_defs.vh ====
/*
 Constants of the flash current level register bank: register
 addresses, field positions, reset values and the narrow current step size.
 Assumes inclusion by bare name from the design files.
*/
`ifndef FLASH_LEVEL_DEFS_VH
`define FLASH_LEVEL_DEFS_VH

`define PREVIEW_LEVEL_ADDR   8'h01
`define STROBE_LEVEL_ADDR    8'h02
`define LEVEL_REG_RESET      8'h00
`define LEVEL_CODE_MSB       7
`define LEVEL_CODE_LSB       4
`define LEVEL_RANGE_BIT      0
`define LEVEL_CODE_W         4
`define STEP_NARROW_MA       9'h00f
`define CURRENT_W            9
`define UNMAPPED_READ        8'h00
`define DEFAULT_DEV_ADDR     7'h2a

`endif

// ==== design/flash_level_scale.v ====
/*
 Level code to per-sink current converter, in whole milliamps.
 Assumes a registered consumer; the result is combinational.
*/
`timescale 1ns/1ps
`include "flash_level_defs.vh"

module flash_level_scale (
    input  wire [`LEVEL_CODE_W-1:0] level_code,
    input  wire                     range_double,
    output wire [`CURRENT_W-1:0]    current_ma
);

    // Code times narrow step, doubled when the range bit is set
    function [`CURRENT_W-1:0] scale;
        input [`LEVEL_CODE_W-1:0] code;
        input                     dbl;
        reg   [`CURRENT_W-1:0]    base;
        begin
            base  = {5'h00, code} * `STEP_NARROW_MA;
            scale = dbl ? {base[`CURRENT_W-2:0], 1'b0} : base;
        end
    endfunction

    assign current_ma = scale(level_code, range_double);

endmodule // flash_level_scale

// ==== design/flash_current_level_regs.v ====
/*
 Flash sink group level registers with their two-wire serial slave
 and the Normal Mode preview/strobe current selection.
 Assumes an open-drain data line resolved outside from sda_oe, and
 trigger and mode pins asynchronous to clk.
*/
// Notes on behaviour
// - Preview level register at 01: code in 7:4, range in bit 0, reset zero.
// - Strobe level register at 02: code in 7:4, range in bit 0, reset zero.
// - Preview current per sink is code times 15 mA, or 30 mA when doubled.
// - Strobe current per sink is code times 15 mA, or 30 mA; zero disables.
// - The level registers set flash sink current only in Normal Mode.
// - Strobe current applies while flash trigger pin high or software requests.
// - Preview current applies while preview trigger pin high or software requests, and no strobe request is active.
`timescale 1ns/1ps
`include "flash_level_defs.vh"

module flash_current_level_regs #(
    parameter [6:0] DEV_ADDR = `DEFAULT_DEV_ADDR  // Arbitrary value
) (
    input  wire                  clk,
    input  wire                  sys_rst,
    input  wire                  ce,
    input  wire                  scl_in,
    input  wire                  sda_in,
    output reg                   sda_out,
    output reg                   sda_oe,
    input  wire                  flash_trigger_pin,
    input  wire                  preview_trigger_pin,
    input  wire                  mode_hard_pin,
    input  wire                  mode_soft_pin,
    input  wire                  sw_strobe_req,
    input  wire                  sw_preview_req,
    output reg  [`CURRENT_W-1:0] flash_sink_a,
    output reg  [`CURRENT_W-1:0] flash_sink_b,
    output reg  [`CURRENT_W-1:0] flash_sink_c,
    output reg                   flash_sinks_on,
    output reg                   normal_mode
);

    localparam [8:0] ST_IDLE  = 9'h001;
    localparam [8:0] ST_ADDR  = 9'h002;
    localparam [8:0] ST_AACK  = 9'h004;
    localparam [8:0] ST_REG   = 9'h008;
    localparam [8:0] ST_RACK  = 9'h010;
    localparam [8:0] ST_WDATA = 9'h020;
    localparam [8:0] ST_WACK  = 9'h040;
    localparam [8:0] ST_RDATA = 9'h080;
    localparam [8:0] ST_MACK  = 9'h100;

    reg  [2:0]  scl_s_q;
    reg  [2:0]  sda_s_q;
    reg  [1:0]  pin_s1_q;
    reg  [1:0]  pin_s2_q;
    reg  [1:0]  mode_s1_q;
    reg  [1:0]  mode_s2_q;
    reg  [8:0]  state_q;
    reg  [3:0]  bitcnt_q;
    reg  [7:0]  shift_q;
    reg  [7:0]  ptr_q;
    reg         rw_q;
    reg         mack_q;
    reg  [7:0]  preview_q;
    reg  [7:0]  strobe_q;
    wire        scl_rise;
    wire        scl_fall;
    wire        bus_start;
    wire        bus_stop;
    wire [7:0]  rx_byte;
    wire [`CURRENT_W-1:0] preview_ma;
    wire [`CURRENT_W-1:0] strobe_ma;
    wire        strobe_act;
    wire        preview_act;
    reg  [`CURRENT_W-1:0] sel_ma_d;
    wire [7:0]  rd_cur;
    wire [7:0]  rd_next;

    // Read-back view; unused bits 3:1 read as zero
    function [7:0] reg_read;
        input [7:0] addr;
        input [7:0] prv;
        input [7:0] stb;
        begin
            case (addr)
                `PREVIEW_LEVEL_ADDR: reg_read = {prv[7:4], 3'h0, prv[0]};
                `STROBE_LEVEL_ADDR:  reg_read = {stb[7:4], 3'h0, stb[0]};
                default:             reg_read = `UNMAPPED_READ;
            endcase
        end
    endfunction

    // Edge logic reads only second and third stages
    assign scl_rise  = scl_s_q[1] & ~scl_s_q[2];
    assign scl_fall  = ~scl_s_q[1] & scl_s_q[2];
    assign bus_start = scl_s_q[1] & scl_s_q[2] & ~sda_s_q[1] & sda_s_q[2];
    assign bus_stop  = scl_s_q[1] & scl_s_q[2] & sda_s_q[1] & ~sda_s_q[2];
    assign rx_byte   = shift_q;

    // Both read views ready ahead, so the ack edge loads a byte with no extra cycle
    assign rd_cur    = reg_read(ptr_q, preview_q, strobe_q);
    assign rd_next   = reg_read(ptr_q + 8'h01, preview_q, strobe_q);

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_s_q   <= 3'h7;
            sda_s_q   <= 3'h7;
            pin_s1_q  <= 2'h0;
            pin_s2_q  <= 2'h0;
            mode_s1_q <= 2'h3;
            mode_s2_q <= 2'h3;
        end else if (ce) begin
            scl_s_q   <= {scl_s_q[1:0], scl_in};
            sda_s_q   <= {sda_s_q[1:0], sda_in};
            pin_s1_q  <= {flash_trigger_pin, preview_trigger_pin};
            pin_s2_q  <= pin_s1_q;
            mode_s1_q <= {mode_hard_pin, mode_soft_pin};
            mode_s2_q <= mode_s1_q;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q   <= ST_IDLE;
            bitcnt_q  <= 4'h0;
            shift_q   <= 8'h00;
            ptr_q     <= 8'h00;
            rw_q      <= 1'b0;
            mack_q    <= 1'b0;
            sda_out   <= 1'b0;
            sda_oe    <= 1'b0;
            preview_q <= `LEVEL_REG_RESET;
            strobe_q  <= `LEVEL_REG_RESET;
        end else if (ce) begin
            if (bus_stop) begin
                state_q <= ST_IDLE;
                sda_oe  <= 1'b0;
            end else if (bus_start) begin
                // Repeated start keeps the pointer for a following read
                state_q  <= ST_ADDR;
                bitcnt_q <= 4'h0;
                sda_oe   <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    ST_ADDR, ST_REG, ST_WDATA: begin
                        if (scl_rise && bitcnt_q != 4'h8) begin
                            shift_q  <= {shift_q[6:0], sda_s_q[1]};
                            bitcnt_q <= bitcnt_q + 4'h1;
                        end else if (scl_fall && bitcnt_q == 4'h8) begin
                            bitcnt_q <= 4'h0;
                            if (state_q == ST_ADDR) begin
                                if (rx_byte[7:1] == DEV_ADDR) begin
                                    rw_q    <= rx_byte[0];
                                    sda_oe  <= 1'b1;
                                    state_q <= ST_AACK;
                                end else begin
                                    state_q <= ST_IDLE;
                                end
                            end else if (state_q == ST_REG) begin
                                ptr_q   <= rx_byte;
                                sda_oe  <= 1'b1;
                                state_q <= ST_RACK;
                            end else begin
                                // Unmapped writes are acknowledged and dropped
                                if (ptr_q == `PREVIEW_LEVEL_ADDR)
                                    preview_q <= {rx_byte[7:4], 3'h0, rx_byte[0]};
                                if (ptr_q == `STROBE_LEVEL_ADDR)
                                    strobe_q <= {rx_byte[7:4], 3'h0, rx_byte[0]};
                                ptr_q   <= ptr_q + 8'h01;
                                sda_oe  <= 1'b1;
                                state_q <= ST_WACK;
                            end
                        end
                    end
                    ST_AACK: begin
                        if (scl_fall) begin
                            if (rw_q) begin
                                shift_q  <= rd_cur;
                                sda_oe   <= ~rd_cur[7];
                                bitcnt_q <= 4'h0;
                                state_q  <= ST_RDATA;
                            end else begin
                                sda_oe  <= 1'b0;
                                state_q <= ST_REG;
                            end
                        end
                    end
                    ST_RACK, ST_WACK: begin
                        if (scl_fall) begin
                            sda_oe  <= 1'b0;
                            state_q <= ST_WDATA;
                        end
                    end
                    ST_RDATA: begin
                        if (scl_fall) begin
                            if (bitcnt_q == 4'h7) begin
                                sda_oe  <= 1'b0;
                                state_q <= ST_MACK;
                            end else begin
                                shift_q  <= {shift_q[6:0], 1'b0};
                                sda_oe   <= ~shift_q[6];
                                bitcnt_q <= bitcnt_q + 4'h1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            mack_q <= ~sda_s_q[1];
                        end else if (scl_fall) begin
                            if (mack_q) begin
                                shift_q  <= rd_next;
                                sda_oe   <= ~rd_next[7];
                                ptr_q    <= ptr_q + 8'h01;
                                bitcnt_q <= 4'h0;
                                state_q  <= ST_RDATA;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                        sda_oe  <= 1'b0;
                    end
                endcase
            end
        end
    end

    flash_level_scale u_preview_scale (
        .level_code   (preview_q[`LEVEL_CODE_MSB:`LEVEL_CODE_LSB]),
        .range_double (preview_q[`LEVEL_RANGE_BIT]),
        .current_ma   (preview_ma)
    );

    flash_level_scale u_strobe_scale (
        .level_code   (strobe_q[`LEVEL_CODE_MSB:`LEVEL_CODE_LSB]),
        .range_double (strobe_q[`LEVEL_RANGE_BIT]),
        .current_ma   (strobe_ma)
    );

    assign strobe_act  = pin_s2_q[1] | sw_strobe_req;
    assign preview_act = pin_s2_q[0] | sw_preview_req;

    // Other modes own the sinks; here they are held at zero
    always @* begin
        sel_ma_d = {`CURRENT_W{1'b0}};
        if (mode_s2_q == 2'h0) begin
            if (strobe_act)
                sel_ma_d = strobe_ma;
            else if (preview_act)
                sel_ma_d = preview_ma;
        end
    end

    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flash_sink_a   <= {`CURRENT_W{1'b0}};
            flash_sink_b   <= {`CURRENT_W{1'b0}};
            flash_sink_c   <= {`CURRENT_W{1'b0}};
            flash_sinks_on <= 1'b0;
            normal_mode    <= 1'b0;
        end else if (ce) begin
            // Three sinks move as one block
            flash_sink_a   <= sel_ma_d;
            flash_sink_b   <= sel_ma_d;
            flash_sink_c   <= sel_ma_d;
            flash_sinks_on <= sel_ma_d != {`CURRENT_W{1'b0}};
            normal_mode    <= mode_s2_q == 2'h0;
        end
    end

endmodule // flash_current_level_regs

// ==== testbench/flash_level_props.sv ====
/* Output checker for the flash level bank.
   Assumes binding to the top module, one clock, async reset. */
`timescale 1ns/1ps
`include "flash_level_defs.vh"
module flash_level_props (
    input wire                  clk,
    input wire                  sys_rst,
    input wire                  ce,
    input wire                  scl_in,
    input wire                  sda_in,
    input wire                  sda_out,
    input wire                  sda_oe,
    input wire                  flash_trigger_pin,
    input wire                  preview_trigger_pin,
    input wire                  mode_hard_pin,
    input wire                  mode_soft_pin,
    input wire                  sw_strobe_req,
    input wire                  sw_preview_req,
    input wire                  flash_sinks_on,
    input wire                  normal_mode,
    input wire [`CURRENT_W-1:0] flash_sink_a,
    input wire [`CURRENT_W-1:0] flash_sink_b,
    input wire [`CURRENT_W-1:0] flash_sink_c
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_sinks_match: assert property (flash_sink_a == flash_sink_b && flash_sink_a == flash_sink_c)
        else $error("Sink currents differ");
    a_on_flag: assert property (flash_sinks_on == (flash_sink_a != 9'h000))
        else $error("Sink enable disagrees with current");
    a_step_size: assert property (flash_sink_a % 15 == 0)
        else $error("Current off the 15 mA grid");
    a_max_level: assert property (flash_sink_a <= 450)
        else $error("Current above 450 mA");
    a_drain_only: assert property (sda_out == 1'b0)
        else $error("Data line driven high");
    a_mode_off: assert property (!normal_mode && !$past(normal_mode) |-> flash_sink_a == 9'h000)
        else $error("Current outside Normal Mode");
    a_mode_decode: assert property ((ce && mode_hard_pin)[*4] |=> !normal_mode)
        else $error("Normal Mode with hard strap");
    a_idle_zero: assert property ((ce && !flash_trigger_pin && !preview_trigger_pin
        && !sw_strobe_req && !sw_preview_req)[*4] |=> flash_sink_a == 9'h000)
        else $error("Current with no request");
    a_reset_clear: assert property (disable iff (1'b0) sys_rst && $past(sys_rst) |->
        flash_sink_a == 9'h000 && !sda_oe && !normal_mode)
        else $error("Outputs not cleared in reset");
endmodule // flash_level_props

// ==== testbench/i2c_host_model.sv ====
/* Two-wire host driving the register bank.
   Assumes a pull-up on data; device pulls low via dev_oe. */
`timescale 1ns/1ps
`include "flash_level_defs.vh"
module i2c_host_model #(
    parameter [6:0] DEV = `DEFAULT_DEV_ADDR
) (
    input  wire clk,
    input  wire dev_oe,
    output reg  scl,
    output wire sda
);
    reg low_q = 1'b0;
    reg got;
    // Wired-and: released line reads the pull-up level
    assign sda = ~(low_q | dev_oe);
    initial scl = 1'b1;
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task bit_io(input b);
        low_q <= ~b;
        tick(4);
        scl <= 1'b1;
        tick(8);
        got = sda;
        scl <= 1'b0;
        tick(4);
    endtask
    // Also serves as repeated start, since data is released first
    task start;
        low_q <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        low_q <= 1'b1;
        tick(4);
        scl <= 1'b0;
        tick(4);
    endtask
    task stop;
        low_q <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        low_q <= 1'b0;
        tick(4);
    endtask
    task byte_io(input [7:0] tx, output [7:0] rx, output ack);
        integer i;
        for (i = 7; i >= 0; i = i - 1) begin
            bit_io(tx[i]);
            rx[i] = got;
        end
        bit_io(1'b1);
        ack = ~got;
    endtask
    task write(input [6:0] dev, input [7:0] ptr, input [7:0] data, output ok);
        reg [7:0] r;
        reg a1, a2, a3;
        start;
        byte_io({dev, 1'b0}, r, a1);
        byte_io(ptr, r, a2);
        byte_io(data, r, a3);
        stop;
        ok = a1 & a2 & a3;
    endtask
    task read(input [7:0] ptr, output [7:0] data);
        reg [7:0] r;
        reg a;
        start;
        byte_io({DEV, 1'b0}, r, a);
        byte_io(ptr, r, a);
        start;
        byte_io({DEV, 1'b1}, r, a);
        // Released ack slot doubles as the closing no-ack
        byte_io(8'hff, data, a);
        stop;
    endtask
endmodule // i2c_host_model

// ==== testbench/tb_flash_current_level_regs.sv ====
/* Self-checking bench for the flash level bank.
   Assumes the host model and checker files compiled first. */
`timescale 1ns/1ps
`include "flash_level_defs.vh"
module tb_flash_current_level_regs;
    reg         clk = 1'b0, sys_rst = 1'b1, ce = 1'b1;
    reg         ftp = 1'b0, ptp = 1'b0, mhp = 1'b0, msp = 1'b0, ssr = 1'b0, spr = 1'b0;
    reg  [7:0]  prv_m, stb_m, rd;
    reg  [31:0] r;
    reg         ok;
    integer     seed = 60777, bad_count = 0, samples_checked = 0, i, j, e;
    wire        scl, sda, sda_out, sda_oe, sinks_on, nm;
    wire [8:0]  sa, sb, sc;
    initial forever #2.5 clk = ~clk;
    flash_current_level_regs DUT (.clk(clk), .sys_rst(sys_rst), .ce(ce), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .flash_trigger_pin(ftp), .preview_trigger_pin(ptp),
        .mode_hard_pin(mhp), .mode_soft_pin(msp), .sw_strobe_req(ssr), .sw_preview_req(spr),
        .flash_sink_a(sa), .flash_sink_b(sb), .flash_sink_c(sc), .flash_sinks_on(sinks_on), .normal_mode(nm));
    i2c_host_model host (.clk(clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));
    function integer level_ma(input [7:0] v);
        level_ma = v[7:4] * (v[0] ? 30 : 15);
    endfunction
    task check(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task results;
        $display("Checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        host.read(8'h01, rd);
        check(rd, 8'h00);
        host.read(8'h02, rd);
        check(rd, 8'h00);
        host.write(`DEFAULT_DEV_ADDR ^ 7'h01, 8'h01, 8'hff, ok);
        check(ok, 1'b0);
        host.write(`DEFAULT_DEV_ADDR, 8'h03, 8'h77, ok);
        check(ok, 1'b1);
        host.read(8'h03, rd);
        check(rd, 8'h00);
        $display("Test reset and refusals done");
        for (i = 0; i < 16; i = i + 1) begin
            prv_m = $random(seed);
            stb_m = $random(seed);
            // Force the zero code and the full-scale doubled code once
            if (i == 0) begin
                prv_m = 8'h0e;
                stb_m = 8'hf1;
            end
            host.write(`DEFAULT_DEV_ADDR, 8'h01, prv_m, ok);
            check(ok, 1'b1);
            host.write(`DEFAULT_DEV_ADDR, 8'h02, stb_m, ok);
            check(ok, 1'b1);
            host.read(8'h01, rd);
            check(rd, prv_m & 8'hf1);
            host.read(8'h02, rd);
            check(rd, stb_m & 8'hf1);
            for (j = 0; j < 8; j = j + 1) begin
                r = $random(seed);
                mhp <= r[0] & r[1] & r[2];
                msp <= r[3] & r[4] & r[5];
                ftp <= r[6];
                ptp <= r[7];
                ssr <= r[8];
                spr <= r[9];
                repeat (6) @(posedge clk);
                e = (mhp | msp) ? 0 : (ftp | ssr) ? level_ma(stb_m) : (ptp | spr) ? level_ma(prv_m) : 0;
                check(sa, e);
                check(sinks_on, e != 0);
                check(nm, !(mhp | msp));
            end
        end
        $display("Test level and selection done");
        // Clock enable low must freeze the whole output path
        stb_m = 8'h91;
        host.write(`DEFAULT_DEV_ADDR, 8'h02, stb_m, ok);
        check(ok, 1'b1);
        {mhp, msp, ftp, ptp, ssr, spr} <= 6'h00;
        repeat (6) @(posedge clk);
        check(sa, 0);
        ce <= 1'b0;
        ssr <= 1'b1;
        repeat (6) @(posedge clk);
        check(sa, 0);
        ce <= 1'b1;
        repeat (6) @(posedge clk);
        check(sa, level_ma(stb_m));
        // Mid-run reset must clear a nonzero level
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        host.read(8'h02, rd);
        check(rd, 8'h00);
        $display("Test freeze and reset done");
        results;
    end
    initial begin
        #400000;
        bad_count = bad_count + 1;
        results;
    end
endmodule // tb_flash_current_level_regs
bind flash_current_level_regs flash_level_props chk_i (.clk(clk), .sys_rst(sys_rst), .ce(ce), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .flash_trigger_pin(flash_trigger_pin),
    .preview_trigger_pin(preview_trigger_pin), .mode_hard_pin(mode_hard_pin), .mode_soft_pin(mode_soft_pin),
    .sw_strobe_req(sw_strobe_req), .sw_preview_req(sw_preview_req), .flash_sinks_on(flash_sinks_on),
    .normal_mode(normal_mode), .flash_sink_a(flash_sink_a), .flash_sink_b(flash_sink_b), .flash_sink_c(flash_sink_c));
